// file: src/ufc_params.svh
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH


// ---------------------------------------------------------------
// bus geometry: byte address is four times the register index
// ---------------------------------------------------------------
`define UFC_AW          10
`define UFC_DW          32
`define UFC_IDX_SERIAL_CONTROL_REGISTER    8'h98
`define UFC_IDX_SLAVE_ADDRESS   8'hA9
`define UFC_IDX_SLAVE_ADDRESS_MASK   8'hB9
`define UFC_IDX_PCTL    8'hC0
`define UFC_IDX_STAT    8'hC1
`define UFC_IDX_MASK    8'hC2
`define UFC_IDX_RXD     8'hC3
`define UFC_IDX_TXD     8'hC4

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define UFC_SC_MODEH    7
`define UFC_SC_MODEL    6
`define UFC_SC_MPE      5
`define UFC_SC_REN      4
`define UFC_SC_TB8      3
`define UFC_SC_RB8      2
`define UFC_SC_TI       1
`define UFC_SC_RI       0
`define UFC_PC_FCE      0
`define UFC_EV_RX       0
`define UFC_EV_TX       1
`define UFC_EV_FE       2
`define UFC_EV_W        3

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define UFC_RST_BYTE    8'h00
`define UFC_RST_EV      3'h0
`define UFC_BIT_CYC     868
`define UFC_TX_LEN8     4'hA
`define UFC_TX_LEN9     4'hB

`endif

// file: src/ufc_pkg.sv
`include "ufc_params.svh"

package ufc_pkg;

    // receiver sequence, one-hot
    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } ufc_rx_st_t;

    // one received frame
    typedef struct packed {
        logic [7:0] data;
        logic       bit9;
        logic       stop_ok;
    } ufc_frame_t;

    // apb request from the master
    typedef struct packed {
        logic [`UFC_AW-1:0] paddr;
        logic               psel;
        logic               penable;
        logic               pwrite;
        logic [`UFC_DW-1:0] pwdata;
    } ufc_apb_req_t;

endpackage : ufc_pkg

// file: src/ufc_addr_match.sv
`timescale 1ns/1ps
`include "ufc_params.svh"

module ufc_addr_match (
    // received address and programmed pattern
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] slave_address_i,
    input  wire logic [7:0] slave_address_mask_i,
    // result
    output logic            match_o
);
    import ufc_pkg::*;

    // compare only where the mask has ones
    function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        masked_eq = ((a ^ v) & m) == 8'h00;
    endfunction : masked_eq

    logic [7:0] bcast;

    // given address or broadcast; an all-zero mask makes the given-address compare match anything
    assign bcast   = slave_address_i | slave_address_mask_i;
    assign match_o = masked_eq(addr_i, slave_address_i, slave_address_mask_i) | masked_eq(addr_i, bcast, bcast);

endmodule : ufc_addr_match

// file: src/ufc_rx.sv
`timescale 1ns/1ps
`include "ufc_params.svh"

module ufc_rx #(
    parameter int BIT_CYC = `UFC_BIT_CYC
) (
    // clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          rst_n_i,
    // control
    input  wire logic          en_i,
    input  wire logic          nine_i,
    input  wire logic          fce_i,
    // serial line
    input  wire logic          rxd_i,
    // result
    output logic               done_o,
    output ufc_pkg::ufc_frame_t frame_o
);
    import ufc_pkg::*;

    localparam int CW = $clog2(BIT_CYC + 1);

    if (BIT_CYC < 4) begin : g_bad_cyc
        $error("ufc_rx: BIT_CYC below 4");
    end

    // ---------------------------------------------------------------
    // frame formatting
    // ---------------------------------------------------------------
    // bits arrive lsb first, so an 8-bit frame sits in the top of the shifter
    function automatic ufc_frame_t fmt(input logic [8:0] s, input logic nine, input logic stop);
        fmt.data    = nine ? s[7:0] : s[8:1];
        fmt.bit9    = nine & s[8];
        fmt.stop_ok = stop;
    endfunction : fmt

    ufc_rx_st_t    state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [3:0]    bitn_r, bitn_nxt;
    logic [8:0]    shf_r, shf_nxt;
    ufc_frame_t    frame_r, frame_nxt;
    logic          done_r, done_nxt;
    logic [8:0]    shf_in;
    logic [3:0]    last_bit;

    assign shf_in   = {rxd_i, shf_r[8:1]};
    assign last_bit = nine_i ? 4'h8 : 4'h7;

    // ---------------------------------------------------------------
    // receive sequence
    // ---------------------------------------------------------------
    // sampling at mid-bit; start bit rechecked to reject glitches
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        bitn_nxt  = bitn_r;
        shf_nxt   = shf_r;
        frame_nxt = frame_r;
        done_nxt  = 1'b0;
        if (cnt_r != '0) begin
            cnt_nxt = cnt_r - CW'(1);
        end
        case (state_r)
            RX_IDLE: begin
                if (en_i && !rxd_i) begin
                    state_nxt = RX_START;
                    cnt_nxt   = CW'(BIT_CYC / 2);
                end
            end
            RX_START: begin
                if (cnt_r == '0) begin
                    state_nxt = rxd_i ? RX_IDLE : RX_DATA;
                    cnt_nxt   = CW'(BIT_CYC - 1);
                    bitn_nxt  = 4'h0;
                end
            end
            RX_DATA: begin
                if (cnt_r == '0) begin
                    shf_nxt  = shf_in;
                    cnt_nxt  = CW'(BIT_CYC - 1);
                    bitn_nxt = bitn_r + 4'h1;
                    if (bitn_r == last_bit) begin
                        state_nxt = RX_STOP;
                        // unchecked frames report at the last data bit
                        if (!fce_i) begin
                            done_nxt  = 1'b1;
                            frame_nxt = fmt(shf_in, nine_i, 1'b1);
                        end
                    end
                end
            end
            RX_STOP: begin
                if (cnt_r == '0) begin
                    state_nxt = RX_IDLE;
                    // checked frames report in the stop bit with its level
                    if (fce_i) begin
                        done_nxt  = 1'b1;
                        frame_nxt = fmt(shf_r, nine_i, rxd_i);
                    end
                end
            end
            default: state_nxt = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_r <= RX_IDLE;
            cnt_r   <= '0;
            bitn_r  <= 4'h0;
            shf_r   <= 9'h000;
            frame_r <= '0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            bitn_r  <= bitn_nxt;
            shf_r   <= shf_nxt;
            frame_r <= frame_nxt;
            done_r  <= done_nxt;
        end
    end

    assign done_o  = done_r;
    assign frame_o = frame_r;

    // done comes from the stop bit when checking, else from the data phase
    rx_done_point_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        done_o |-> ($past(fce_i) ? $past(state_r) == RX_STOP : $past(state_r) == RX_DATA))
        else $error("receive done at wrong point of frame");

endmodule : ufc_rx

// file: src/ufc_top.sv
`timescale 1ns/1ps
`include "ufc_params.svh"

module ufc_top #(
    parameter int RX_BIT_CYC = `UFC_BIT_CYC,
    parameter int TX_BIT_CYC = `UFC_BIT_CYC
) (
    // clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               rst_n_i,
    // apb slave
    input  ufc_pkg::ufc_apb_req_t   apb_i,
    output logic [`UFC_DW-1:0]      prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    // serial line
    input  wire logic               rxd_i,
    output logic                    txd_o,
    // interrupt
    output logic                    irq_o
);
    import ufc_pkg::*;

    localparam int TCW = $clog2(TX_BIT_CYC + 1);

    if (TX_BIT_CYC < 4) begin : g_bad_tx
        $error("ufc_top: TX_BIT_CYC below 4");
    end

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    function automatic logic is_reg(input logic [`UFC_AW-1:0] a, input logic [7:0] idx);
        is_reg = (a == {idx, 2'b00});
    endfunction : is_reg

    logic [7:0]           serial_control_register_r, serial_control_register_nxt;
    logic                 fe_r, fe_nxt;
    logic [7:0]           pctl_r, pctl_nxt;
    logic [7:0]           slave_address_r, slave_address_nxt;
    logic [7:0]           slave_address_mask_r, slave_address_mask_nxt;
    logic [7:0]           sbuf_r, sbuf_nxt;
    logic [`UFC_EV_W-1:0] stat_r, stat_nxt;
    logic [`UFC_EV_W-1:0] mask_r, mask_nxt;
    logic [`UFC_DW-1:0]   prdata_r, prdata_nxt;
    logic [10:0]          tx_shf_r, tx_shf_nxt;
    logic [TCW-1:0]       tx_cnt_r, tx_cnt_nxt;
    logic [3:0]           tx_left_r, tx_left_nxt;

    logic                 setup, acc, hit, wr;
    logic [`UFC_AW-1:0]   a;
    logic [7:0]           pw;
    logic                 fce, async_mode, nine, mpe;
    logic                 rx_done, rx_match, rx_take, fe_ev, tx_ev, tx_start;
    logic [`UFC_EV_W-1:0] ev;
    ufc_frame_t           rx_frame;

    // apb phases; no wait states, so pready stays high
    assign a         = apb_i.paddr;
    assign pw        = apb_i.pwdata[7:0];
    assign setup     = apb_i.psel & ~apb_i.penable;
    assign acc       = apb_i.psel & apb_i.penable;
    assign hit       = is_reg(a, `UFC_IDX_SERIAL_CONTROL_REGISTER) | is_reg(a, `UFC_IDX_SLAVE_ADDRESS) | is_reg(a, `UFC_IDX_SLAVE_ADDRESS_MASK)
                     | is_reg(a, `UFC_IDX_PCTL) | is_reg(a, `UFC_IDX_STAT) | is_reg(a, `UFC_IDX_MASK)
                     | is_reg(a, `UFC_IDX_RXD) | is_reg(a, `UFC_IDX_TXD);
    assign wr        = acc & apb_i.pwrite & hit;
    assign pready_o  = 1'b1;
    assign pslverr_o = acc & ~hit;
    assign prdata_o  = prdata_r;

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    // shift mode (both mode bits low) keeps the receiver and checker idle
    assign fce        = pctl_r[`UFC_PC_FCE];
    assign async_mode = serial_control_register_r[`UFC_SC_MODEH] | serial_control_register_r[`UFC_SC_MODEL];
    assign nine       = serial_control_register_r[`UFC_SC_MODEH];
    assign mpe        = serial_control_register_r[`UFC_SC_MPE];

    ufc_rx #(
        .BIT_CYC (RX_BIT_CYC)
    ) u_rx (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .en_i      (serial_control_register_r[`UFC_SC_REN] & async_mode),
        .nine_i    (nine),
        .fce_i     (fce),
        .rxd_i     (rxd_i),
        .done_o    (rx_done),
        .frame_o   (rx_frame)
    );

    ufc_addr_match u_match (
        .addr_i  (rx_frame.data),
        .slave_address_i (slave_address_r),
        .slave_address_mask_i (slave_address_mask_r),
        .match_o (rx_match)
    );

    // ---------------------------------------------------------------
    // receive acceptance and error events
    // ---------------------------------------------------------------
    // with multiprocessor enable in nine-bit modes, only matching address frames pass
    assign rx_take = rx_done & async_mode & (~(mpe & nine) | (rx_frame.bit9 & rx_match));
    // error judged on every checked frame, accepted or not
    assign fe_ev   = rx_done & async_mode & fce & ~rx_frame.stop_ok;
    assign ev      = {fe_ev, tx_ev, rx_take};

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    // hardware sets are applied after software writes so a set in the
    // clearing cycle is not lost
    always_comb begin
        serial_control_register_nxt  = serial_control_register_r;
        fe_nxt    = fe_r;
        pctl_nxt  = pctl_r;
        slave_address_nxt = slave_address_r;
        slave_address_mask_nxt = slave_address_mask_r;
        sbuf_nxt  = sbuf_r;
        mask_nxt  = mask_r;
        stat_nxt  = stat_r;
        if (wr && is_reg(a, `UFC_IDX_SERIAL_CONTROL_REGISTER)) begin
            serial_control_register_nxt = pw;
            // bit 7 steers to the error flag while checking is on
            if (fce) begin
                serial_control_register_nxt[`UFC_SC_MODEH] = serial_control_register_r[`UFC_SC_MODEH];
                fe_nxt                  = pw[`UFC_SC_MODEH];
            end
        end
        if (wr && is_reg(a, `UFC_IDX_SLAVE_ADDRESS)) begin
            slave_address_nxt = pw;
        end
        if (wr && is_reg(a, `UFC_IDX_SLAVE_ADDRESS_MASK)) begin
            slave_address_mask_nxt = pw;
        end
        if (wr && is_reg(a, `UFC_IDX_PCTL)) begin
            pctl_nxt = {7'h00, pw[`UFC_PC_FCE]};
        end
        if (wr && is_reg(a, `UFC_IDX_MASK)) begin
            mask_nxt = pw[`UFC_EV_W-1:0];
        end
        if (wr && is_reg(a, `UFC_IDX_STAT)) begin
            stat_nxt = stat_r & ~pw[`UFC_EV_W-1:0];
        end
        stat_nxt = stat_nxt | ev;
        if (rx_take) begin
            sbuf_nxt                = rx_frame.data;
            serial_control_register_nxt[`UFC_SC_RI]    = 1'b1;
            // mode 1 reports the stop level in the ninth-bit slot when checked, else a one
            serial_control_register_nxt[`UFC_SC_RB8]   = nine ? rx_frame.bit9 : rx_frame.stop_ok;
        end
        if (tx_ev) begin
            serial_control_register_nxt[`UFC_SC_TI] = 1'b1;
        end
        // only a software write or reset clears it; good frames never do
        if (fe_ev) begin
            fe_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            serial_control_register_r  <= `UFC_RST_BYTE;
            fe_r    <= 1'b0;
            pctl_r  <= `UFC_RST_BYTE;
            slave_address_r <= `UFC_RST_BYTE;
            slave_address_mask_r <= `UFC_RST_BYTE;
            sbuf_r  <= `UFC_RST_BYTE;
            stat_r  <= `UFC_RST_EV;
            mask_r  <= `UFC_RST_EV;
        end else begin
            serial_control_register_r  <= serial_control_register_nxt;
            fe_r    <= fe_nxt;
            pctl_r  <= pctl_nxt;
            slave_address_r <= slave_address_nxt;
            slave_address_mask_r <= slave_address_mask_nxt;
            sbuf_r  <= sbuf_nxt;
            stat_r  <= stat_nxt;
            mask_r  <= mask_nxt;
        end
    end

    // level interrupt from sticky status gated by mask
    assign irq_o = |(stat_r & mask_r);

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    // captured in the setup cycle so prdata comes from a flop
    always_comb begin
        prdata_nxt = prdata_r;
        if (setup) begin
            prdata_nxt = '0;
            if (is_reg(a, `UFC_IDX_SERIAL_CONTROL_REGISTER)) begin
                prdata_nxt[7:0] = {fce ? fe_r : serial_control_register_r[`UFC_SC_MODEH], serial_control_register_r[6:0]};
            end
            if (is_reg(a, `UFC_IDX_SLAVE_ADDRESS)) begin
                prdata_nxt[7:0] = slave_address_r;
            end
            if (is_reg(a, `UFC_IDX_SLAVE_ADDRESS_MASK)) begin
                prdata_nxt[7:0] = slave_address_mask_r;
            end
            if (is_reg(a, `UFC_IDX_PCTL)) begin
                prdata_nxt[7:0] = pctl_r;
            end
            if (is_reg(a, `UFC_IDX_STAT)) begin
                prdata_nxt[`UFC_EV_W-1:0] = stat_r;
            end
            if (is_reg(a, `UFC_IDX_MASK)) begin
                prdata_nxt[`UFC_EV_W-1:0] = mask_r;
            end
            if (is_reg(a, `UFC_IDX_RXD)) begin
                prdata_nxt[7:0] = sbuf_r;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            prdata_r <= '0;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // ---------------------------------------------------------------
    // transmitter
    // ---------------------------------------------------------------
    // own bit counter, fully apart from the receiver; a write while busy is dropped
    assign tx_start = wr & is_reg(a, `UFC_IDX_TXD) & (tx_left_r == 4'h0) & async_mode;
    // done flag at the start of the stop bit
    assign tx_ev    = (tx_left_r == 4'h2) & (tx_cnt_r == '0);

    always_comb begin
        tx_shf_nxt  = tx_shf_r;
        tx_cnt_nxt  = tx_cnt_r;
        tx_left_nxt = tx_left_r;
        if (tx_left_r != 4'h0) begin
            if (tx_cnt_r == '0) begin
                tx_shf_nxt  = {1'b1, tx_shf_r[10:1]};
                tx_left_nxt = tx_left_r - 4'h1;
                tx_cnt_nxt  = TCW'(TX_BIT_CYC - 1);
            end else begin
                tx_cnt_nxt = tx_cnt_r - TCW'(1);
            end
        end else if (tx_start) begin
            tx_shf_nxt  = nine ? {1'b1, serial_control_register_r[`UFC_SC_TB8], pw, 1'b0} : {2'b11, pw, 1'b0};
            tx_left_nxt = nine ? `UFC_TX_LEN9 : `UFC_TX_LEN8;
            tx_cnt_nxt  = TCW'(TX_BIT_CYC - 1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tx_shf_r  <= 11'h7FF;
            tx_cnt_r  <= '0;
            tx_left_r <= 4'h0;
        end else begin
            tx_shf_r  <= tx_shf_nxt;
            tx_cnt_r  <= tx_cnt_nxt;
            tx_left_r <= tx_left_nxt;
        end
    end

    // idle line is high because the shifter refills with ones
    assign txd_o = tx_shf_r[0];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic serial_control_register_wr;
    assign serial_control_register_wr = wr & is_reg(a, `UFC_IDX_SERIAL_CONTROL_REGISTER);

    fe_set_bad_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rx_done && async_mode && fce && !rx_frame.stop_ok |=> fe_r)
        else $error("framing error flag not set on bad stop bit");

    fe_sticky_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fe_r && !(serial_control_register_wr && fce && !pw[`UFC_SC_MODEH]) |=> fe_r)
        else $error("framing error flag dropped without software clear");

    fe_good_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fe_r && rx_done && rx_frame.stop_ok && !serial_control_register_wr |=> fe_r ##1 fe_r)
        else $error("good frame cleared framing error flag");

    fe_no_check_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !fce && !serial_control_register_wr && !fe_r |=> !fe_r)
        else $error("framing error flag set while checking disabled");

    shift_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !async_mode && !serial_control_register_wr && !serial_control_register_r[`UFC_SC_RI] |=> !serial_control_register_r[`UFC_SC_RI])
        else $error("receive done raised in shift mode");

    addr_drop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rx_done && mpe && nine && !(rx_match && rx_frame.bit9) && !serial_control_register_wr && !serial_control_register_r[`UFC_SC_RI]
        |=> !serial_control_register_r[`UFC_SC_RI] && $stable(sbuf_r))
        else $error("unmatched address frame was accepted");

    bcast_hit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rx_frame.data == (slave_address_r | slave_address_mask_r) |-> rx_match)
        else $error("broadcast address not recognised");

    given_hit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ((rx_frame.data ^ slave_address_r) & slave_address_mask_r) == 8'h00 |-> rx_match)
        else $error("masked slave address not recognised");

    reset_any_a: assert property (@(posedge clk_sys_i)
        !rst_n_i |=> slave_address_r == `UFC_RST_BYTE && slave_address_mask_r == `UFC_RST_BYTE && rx_match)
        else $error("reset did not open address matching");

    tx_flag_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tx_ev |=> serial_control_register_r[`UFC_SC_TI] && stat_r[`UFC_EV_TX] && txd_o)
        else $error("transmit done not flagged at stop bit");

endmodule : ufc_top

// file: bench/ufc_node.sv
`timescale 1ns/1ps

module ufc_node #(
    parameter int BIT = 8
) (
    // clock and serial line
    input  wire logic clk_sys_i,
    output logic      line_o
);
    // a released line sits at its pull-up level
    initial line_o = 1'b1;

    // ---------------------------------------------------------------
    // one frame, lsb first, start low, stop level chosen by caller
    // ---------------------------------------------------------------
    task automatic send(input logic [8:0] d, input logic nine, input logic stp);
        logic [10:0] f;
        int          n;
        f = {stp, d[8], d[7:0], 1'b0};
        n = nine ? 11 : 10;
        if (!nine) f[9] = stp; // eight-bit frame: stop follows bit 7
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_i) line_o <= f[i];
            repeat (BIT - 1) @(posedge clk_sys_i);
        end
        @(posedge clk_sys_i) line_o <= 1'b1;
    endtask : send
endmodule : ufc_node

// file: bench/uart_frame_check_addr_match_test.sv
`timescale 1ns/1ps
`include "ufc_params.svh"

module uart_frame_check_addr_match_test;
    import ufc_pkg::*;
    // ---------------------------------------------------------------
    // addresses: byte address is the index shifted by two
    // ---------------------------------------------------------------
    localparam logic [9:0] A_SC = {`UFC_IDX_SERIAL_CONTROL_REGISTER, 2'b00};
    localparam logic [9:0] A_SA = {`UFC_IDX_SLAVE_ADDRESS, 2'b00};
    localparam logic [9:0] A_SM = {`UFC_IDX_SLAVE_ADDRESS_MASK, 2'b00};
    localparam logic [9:0] A_PC = {`UFC_IDX_PCTL, 2'b00};
    localparam logic [9:0] A_ST = {`UFC_IDX_STAT, 2'b00};
    localparam logic [9:0] A_MK = {`UFC_IDX_MASK, 2'b00};
    localparam logic [9:0] A_RX = {`UFC_IDX_RXD, 2'b00};
    localparam logic [9:0] A_TX = {`UFC_IDX_TXD, 2'b00};
    logic          clk_sys = 1'b0;
    logic          rst_n   = 1'b0;
    ufc_apb_req_t  req     = '0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          line;
    logic          irq;
    logic          txd;
    logic [7:0]    rdat;
    logic          rerr;
    int            num_errors = 0;
    int            cmp_count  = 0;
    int            cyc        = 0;

    always #5 clk_sys = ~clk_sys;

    ufc_node #(.BIT(8)) node (.clk_sys_i(clk_sys), .line_o(line));

    ufc_top #(.RX_BIT_CYC(8), .TX_BIT_CYC(8)) dut (
        .clk_sys_i(clk_sys), .rst_n_i(rst_n), .apb_i(req), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rxd_i(line), .txd_o(txd), .irq_o(irq));

    task automatic end_sim;
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    // hang guard: the whole run needs a few thousand cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // apb cycle: one setup cycle, then hold access until pready is seen high
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys) req <= '{a, 1'b1, 1'b0, w, {24'h0, d}};
        @(posedge clk_sys) req.penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata[7:0];
        rerr = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    // receive one frame, judge done flag and bit 7, then rewrite control
    task automatic rx(input logic [8:0] d, input logic nine, stp, input logic [7:0] sc, input logic ri, fe);
        node.send(d, nine, stp);
        repeat (4) @(posedge clk_sys);
        apb(0, A_SC, 0);
        chk("done flag", rdat[0], ri);
        chk("control bit 7", rdat[7], fe);
        apb(1, A_SC, sc);
    endtask : rx

    task automatic t_regs;
        apb(0, A_SA, 0);
        chk("addr reset", rdat, 0);
        apb(0, A_SM, 0);
        chk("mask reset", rdat, 0);
        apb(1, A_SA, 8'h5A);
        apb(0, A_SA, 0);
        chk("addr rw", rdat, 8'h5A);
        apb(1, A_SM, 8'hA5);
        apb(0, A_SM, 0);
        chk("mask rw", rdat, 8'hA5);
        apb(0, 10'h000, 0);
        chk("unmapped err", rerr, 1);
    endtask : t_regs

    task automatic t_frame;
        apb(1, A_PC, 8'h01);
        apb(1, A_SC, 8'h50);
        rx(9'h0A5, 0, 0, 8'hD0, 1, 1);
        rx(9'h0A5, 0, 1, 8'hD0, 1, 1);
        apb(1, A_SC, 8'h50);
        apb(0, A_SC, 0);
        chk("flag cleared", rdat[7], 0);
        apb(1, A_PC, 8'h00);
        rx(9'h03C, 0, 0, 8'h50, 1, 0);
        apb(1, A_PC, 8'h01);
        apb(1, A_SC, 8'h10);
        rx(9'h0A5, 0, 0, 8'h10, 0, 0);
    endtask : t_frame

    // done flag probed between last data sample and mid-stop sample
    task automatic t_when;
        for (int f = 0; f < 2; f++) begin
            apb(1, A_PC, f[7:0]);
            apb(1, A_SC, 8'h50);
            fork
                node.send(9'h055, 0, 1);
                begin
                    repeat (72) @(posedge clk_sys);
                    apb(0, A_SC, 0);
                    chk("early done", rdat[0], f == 0);
                end
            join
            rx(9'h055, 0, 1, 8'h50, 1, 0);
        end
    endtask : t_when

    task automatic t_addr;
        logic [8:0] fr [5] = '{9'h1F0, 9'h1F2, 9'h1FF, 9'h170, 9'h0F0};
        logic       ac [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        logic [7:0] kept = 8'h37;
        apb(1, A_PC, 8'h00);
        apb(1, A_SA, 8'h00);
        apb(1, A_SM, 8'h00);
        apb(1, A_MK, 8'h01);
        apb(1, A_SC, 8'hB0);
        rx(9'h137, 1, 1, 8'hB0, 1, 1);
        apb(1, A_SA, 8'hF1);
        apb(1, A_SM, 8'hFA);
        apb(1, A_ST, 8'h07);
        for (int i = 0; i < 5; i++) begin
            node.send(fr[i], 1, 1);
            @(negedge clk_sys);
            chk("irq", irq, ac[i]);
            rx(9'h000, 0, 1, 8'hB0, ac[i], 1);
            apb(0, A_RX, 0);
            // dropped frames must leave the last accepted byte in place
            if (ac[i]) kept = fr[i][7:0];
            chk("rx data", rdat, kept);
            apb(1, A_ST, 8'h07);
        end
        apb(1, A_MK, 8'h00);
        node.send(9'h1FF, 1, 1);
        @(negedge clk_sys);
        chk("masked irq", irq, 0);
        apb(0, A_ST, 0);
        chk("status", rdat[0], 1);
    endtask : t_addr

    // transmit while a frame arrives; each direction runs on its own counter
    task automatic t_tx;
        logic [9:0] seen;
        apb(1, A_ST, 8'h07);
        apb(1, A_SC, 8'h50);
        fork
            node.send(9'h0C3, 0, 1);
            begin
                apb(1, A_TX, 8'h96);
                // sample near the middle of each bit cell
                for (int k = 0; k < 10; k++) begin
                    repeat (k == 0 ? 4 : 8) @(negedge clk_sys);
                    seen[k] = txd;
                end
            end
        join
        chk("tx frame", seen, {1'b1, 8'h96, 1'b0});
        apb(0, A_SC, 0);
        chk("tx rx done", rdat[1:0], 2'h3);
        apb(0, A_RX, 0);
        chk("rx beside tx", rdat, 8'hC3);
        apb(0, A_ST, 0);
        chk("tx status", rdat[2:0], 3'h3);
    endtask : t_tx

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_frame();
        t_when();
        t_addr();
        t_tx();
        end_sim();
    end
endmodule : uart_frame_check_addr_match_test
